// [sgcs_pkg.sv]
// constants for the switch global control and status registers
package sgcs_pkg;
    localparam logic [11:0] SGCS_STATUS_OFFSET = 12'h400;
    localparam logic [11:0] SGCS_CONTROL_OFFSET = 12'h404;
    // status fields
    localparam int SGCS_ST_MODE_LSB = 0;
    localparam int SGCS_ST_MODE_MSB = 2;
    localparam int SGCS_ST_CCDS = 5;
    localparam int SGCS_ST_CCUS = 6;
    localparam int SGCS_ST_MSSLOW = 7;
    localparam int SGCS_ST_REFCLK = 8;
    localparam int SGCS_ST_HOLD = 9;
    localparam int SGCS_ST_LOCK_LSB = 20;
    localparam int SGCS_ST_LOCK_MSB = 22;
    localparam int SGCS_ST_MARK_LSB = 28;
    localparam int SGCS_ST_MARK_MSB = 31;
    // control fields
    localparam int SGCS_CT_FULL = 0;
    localparam int SGCS_CT_WARM = 1;
    localparam int SGCS_CT_HOLD = 2;
    localparam int SGCS_CT_UNLOCK = 3;
    localparam int SGCS_CT_PWR = 4;
    localparam int SGCS_CT_NOLD = 5;
    localparam int SGCS_CT_SKIPEE = 6;
    localparam int SGCS_CT_STRICT = 7;
    localparam int SGCS_CT_NOP2P = 8;
    // lock state codes
    localparam logic [2:0] SGCS_LOCK_NONE = 3'h0;
    localparam logic [2:0] SGCS_LOCK_PORT2 = 3'h2;
    localparam logic [2:0] SGCS_LOCK_PORT4 = 3'h4;
    // operating mode codes
    localparam logic [2:0] SGCS_MODE_NORMAL = 3'h0;
    localparam logic [2:0] SGCS_MODE_EEPROM = 3'h1;
    localparam logic [3:0] SGCS_MARK_RESET = 4'h0;
    localparam logic [31:0] SGCS_ZERO = 32'h0;
    typedef enum logic [1:0] {
        SGCS_TRIG_IDLE = 2'b00,
        SGCS_TRIG_WAIT = 2'b01,
        SGCS_TRIG_FIRE = 2'b10
    } sgcs_trig_t;
endpackage

// [sgcs_regs.sv]
// switch global control and status register bank
`timescale 1ns/1ps
module sgcs_regs
    import sgcs_pkg::*;
(
    // clock and resets
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic warm_rst,
    input wire logic reset_op,
    // strap pins
    input wire logic [2:0] operating_mode_strap,
    input wire logic common_clock_downstream_strap,
    input wire logic common_clock_upstream_strap,
    input wire logic master_serial_slow_strap,
    input wire logic reference_clock_mode_strap,
    input wire logic reset_hold_strap,
    // lock state from the port logic
    input wire logic [2:0] upstream_lock_state,
    // register access
    input wire logic reg_req,
    input wire logic reg_wr,
    input wire logic reg_eeprom,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_done,
    // completion sent for the last write
    input wire logic cpl_sent,
    // reset and policy outputs
    output logic full_reset_req,
    output logic warm_reset_req,
    output logic upstream_retrain_req,
    output logic core_hold,
    output logic write_when_unlocked,
    output logic power_value_write_enable,
    output logic no_linkdown_warm_reset,
    output logic skip_eeprom_on_warm_reset,
    output logic force_strict_ordering,
    output logic block_peer_traffic,
    output logic eeprom_init_mode
);
    logic [2:0] mode_q;
    logic [4:0] strap_q;
    logic hold_sampling;
    logic [2:0] lock_q;
    logic [3:0] marker;
    logic reset_hold;
    logic unlock;
    logic pwr_en;
    logic nold;
    logic skipee;
    logic strict;
    logic nop2p;
    logic wr_ctl;
    logic wr_sts;
    logic full_pend;
    logic warm_pend;
    sgcs_trig_t trig_state;
    logic [31:0] status_word;
    logic [31:0] control_word;
    logic [7:0] strap_pins;
    logic [7:0] strap_sync;
    logic [7:0] strap_agree;
    logic strap_settled;
    logic [2:0] mode_sync;
    logic hold_sync;
    logic [3:0] other_sync;

    assign wr_ctl = reg_req && reg_wr && (reg_addr == SGCS_CONTROL_OFFSET);
    assign wr_sts = reg_req && reg_wr && (reg_addr == SGCS_STATUS_OFFSET);

    // strap pins gathered for the synchronisers
    assign strap_pins = {operating_mode_strap, reset_hold_strap, reference_clock_mode_strap,
                         master_serial_slow_strap, common_clock_upstream_strap,
                         common_clock_downstream_strap};

    // three-flop strap synchronisers, unreset so they follow the pins during reset
    for (genvar gi = 0; gi < $bits(strap_pins); gi++) begin : g_strap_sync
        logic stage1;
        logic stage2;
        logic stage3;
        always_ff @(posedge core_clk) begin
            if (clk_en) begin
                stage1 <= strap_pins[gi];
                stage2 <= stage1;
                stage3 <= stage2;
            end
        end
        assign strap_sync[gi] = stage3;
        assign strap_agree[gi] = (stage2 == stage3); // change counts once both agree
    end

    // synchronised straps split back into fields
    assign {mode_sync, hold_sync, other_sync} = strap_sync;
    assign strap_settled = &strap_agree;

    // straps are caught on the first settled enabled edge after fundamental reset release
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_sampling <= 1'b1;
            mode_q <= SGCS_MODE_NORMAL;
            strap_q <= 5'h00;
        end else if (clk_en && hold_sampling && strap_settled) begin
            hold_sampling <= 1'b0;
            mode_q <= mode_sync;
            strap_q <= {hold_sync, other_sync};
        end
    end

    // lock state registered for a flop-sourced read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= SGCS_LOCK_NONE;
        end else if (clk_en) begin
            lock_q <= upstream_lock_state;
        end
    end

    // scratch marker, untouched by warm reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            marker <= SGCS_MARK_RESET;
        end else if (clk_en && wr_sts) begin
            marker <= reg_wdata[SGCS_ST_MARK_MSB:SGCS_ST_MARK_LSB];
        end
    end

    // hold bit: strap during reset op, eeprom write otherwise frozen
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_hold <= 1'b0;
        end else if (clk_en) begin
            if (hold_sampling) begin
                reset_hold <= hold_sync;
            end else if (reset_op) begin
                reset_hold <= hold_sync;
            end else if (wr_ctl && reg_eeprom) begin
                reset_hold <= reg_wdata[SGCS_CT_HOLD];
            end
        end
    end

    // unlock bit set by each reset operation
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            unlock <= 1'b0;
        end else if (clk_en) begin
            if (reset_op) begin
                unlock <= 1'b1;
            end else if (wr_ctl) begin
                unlock <= reg_wdata[SGCS_CT_UNLOCK];
            end
        end
    end

    // power unlock is itself write-when-unlocked
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_en <= 1'b0;
        end else if (clk_en && wr_ctl && unlock) begin
            pwr_en <= reg_wdata[SGCS_CT_PWR];
        end
    end

    // sticky policy bits
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nold <= 1'b0;
            skipee <= 1'b0;
            strict <= 1'b0;
            nop2p <= 1'b0;
        end else if (clk_en && wr_ctl) begin
            nold <= reg_wdata[SGCS_CT_NOLD];
            skipee <= reg_wdata[SGCS_CT_SKIPEE];
            strict <= reg_wdata[SGCS_CT_STRICT];
            nop2p <= reg_wdata[SGCS_CT_NOP2P];
        end
    end

    // pending triggers wait for the write completion
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_state <= SGCS_TRIG_IDLE;
            full_pend <= 1'b0;
            warm_pend <= 1'b0;
        end else if (clk_en) begin
            case (trig_state)
                SGCS_TRIG_IDLE: begin
                    if (wr_ctl && (reg_wdata[SGCS_CT_FULL] || reg_wdata[SGCS_CT_WARM])) begin
                        full_pend <= reg_wdata[SGCS_CT_FULL];
                        warm_pend <= reg_wdata[SGCS_CT_WARM];
                        trig_state <= SGCS_TRIG_WAIT;
                    end
                end
                SGCS_TRIG_WAIT: begin
                    if (cpl_sent) begin
                        trig_state <= SGCS_TRIG_FIRE;
                    end
                end
                SGCS_TRIG_FIRE: begin
                    full_pend <= 1'b0;
                    warm_pend <= 1'b0;
                    trig_state <= SGCS_TRIG_IDLE;
                end
                default: begin
                    trig_state <= SGCS_TRIG_IDLE;
                end
            endcase
        end
    end

    // one-cycle reset pulses only after completion
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            full_reset_req <= 1'b0;
            warm_reset_req <= 1'b0;
            upstream_retrain_req <= 1'b0;
        end else if (clk_en) begin
            full_reset_req <= (trig_state == SGCS_TRIG_WAIT) && cpl_sent && full_pend;
            warm_reset_req <= (trig_state == SGCS_TRIG_WAIT) && cpl_sent && warm_pend;
            upstream_retrain_req <= (trig_state == SGCS_TRIG_WAIT) && cpl_sent && warm_pend;
        end
    end

    // read words; trigger and reserved bits read zero
    always_comb begin
        status_word = SGCS_ZERO;
        status_word[SGCS_ST_MODE_MSB:SGCS_ST_MODE_LSB] = mode_q;
        status_word[SGCS_ST_HOLD:SGCS_ST_CCDS] = strap_q;
        status_word[SGCS_ST_LOCK_MSB:SGCS_ST_LOCK_LSB] = lock_q;
        status_word[SGCS_ST_MARK_MSB:SGCS_ST_MARK_LSB] = marker;
        control_word = SGCS_ZERO;
        control_word[SGCS_CT_HOLD] = reset_hold;
        control_word[SGCS_CT_UNLOCK] = unlock;
        control_word[SGCS_CT_PWR] = pwr_en;
        control_word[SGCS_CT_NOLD] = nold;
        control_word[SGCS_CT_SKIPEE] = skipee;
        control_word[SGCS_CT_STRICT] = strict;
        control_word[SGCS_CT_NOP2P] = nop2p;
    end

    // registered read data and done strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= SGCS_ZERO;
            reg_done <= 1'b0;
        end else if (clk_en) begin
            reg_done <= reg_req;
            if (reg_req && !reg_wr) begin
                if (reg_addr == SGCS_STATUS_OFFSET) begin
                    reg_rdata <= status_word;
                end else if (reg_addr == SGCS_CONTROL_OFFSET) begin
                    reg_rdata <= control_word;
                end else begin
                    reg_rdata <= SGCS_ZERO;
                end
            end
        end
    end

    // policy outputs
    assign core_hold = reset_hold;
    assign write_when_unlocked = unlock;
    assign power_value_write_enable = pwr_en;
    assign no_linkdown_warm_reset = nold;
    assign skip_eeprom_on_warm_reset = skipee;
    assign force_strict_ordering = strict;
    assign block_peer_traffic = nop2p;
    assign eeprom_init_mode = (mode_q == SGCS_MODE_EEPROM);

    // assertions
    property p_trig_after_cpl;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(full_reset_req) |-> $past(cpl_sent);
    endproperty
    a_trig_after_cpl: assert property (p_trig_after_cpl)
        else $error("full reset before completion");

    property p_warm_retrain;
        @(posedge core_clk) disable iff (!rst_n)
        warm_reset_req |-> upstream_retrain_req;
    endproperty
    a_warm_retrain: assert property (p_warm_retrain)
        else $error("warm reset without retrain");

    property p_no_early_fire;
        @(posedge core_clk) disable iff (!rst_n)
        (clk_en && wr_ctl && reg_wdata[SGCS_CT_FULL] && trig_state == SGCS_TRIG_IDLE)
            |=> !full_reset_req;
    endproperty
    a_no_early_fire: assert property (p_no_early_fire)
        else $error("full reset fired with the write");

    property p_unlock_reset_op;
        @(posedge core_clk) disable iff (!rst_n)
        (clk_en && reset_op) |=> unlock;
    endproperty
    a_unlock_reset_op: assert property (p_unlock_reset_op)
        else $error("unlock not set by reset operation");

    property p_pwr_locked;
        @(posedge core_clk) disable iff (!rst_n)
        (clk_en && !unlock) |=> $stable(pwr_en);
    endproperty
    a_pwr_locked: assert property (p_pwr_locked)
        else $error("power unlock changed while locked");

    property p_hold_frozen;
        @(posedge core_clk) disable iff (!rst_n)
        (clk_en && !hold_sampling && !reset_op && !(wr_ctl && reg_eeprom)) |=> $stable(reset_hold);
    endproperty
    a_hold_frozen: assert property (p_hold_frozen)
        else $error("hold bit changed outside reset");

    property p_ctl_trig_zero;
        @(posedge core_clk) disable iff (!rst_n)
        reg_done && $past(reg_addr) == SGCS_CONTROL_OFFSET && !$past(reg_wr)
            |-> reg_rdata[SGCS_CT_WARM:SGCS_CT_FULL] == 2'b00;
    endproperty
    a_ctl_trig_zero: assert property (p_ctl_trig_zero)
        else $error("trigger bits read nonzero");

    property p_marker_kept;
        @(posedge core_clk) disable iff (!rst_n)
        (clk_en && warm_rst && !wr_sts) |=> $stable(marker);
    endproperty
    a_marker_kept: assert property (p_marker_kept)
        else $error("marker changed by warm reset");

    property p_marker_frozen;
        @(posedge core_clk) disable iff (!rst_n)
        !clk_en |=> $stable(marker);
    endproperty
    a_marker_frozen: assert property (p_marker_frozen)
        else $error("marker changed while clock enable low");

    property p_full_single;
        @(posedge core_clk) disable iff (!rst_n)
        (clk_en && full_reset_req) |=> !full_reset_req;
    endproperty
    a_full_single: assert property (p_full_single)
        else $error("full reset request longer than one cycle");
endmodule

// [tb_sgcs_regs.sv]
// self-checking bench for the switch global control and status registers
`timescale 1ns/1ps
module tb_sgcs_regs;
    import sgcs_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic warm_rst = 1'b0;
    logic reset_op = 1'b0;
    logic [2:0] operating_mode_strap = 3'h1;
    logic [4:0] straps = 5'h15; // hold, refclk, slow, upstream, downstream
    logic [2:0] upstream_lock_state = 3'h0;
    logic reg_req = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_eeprom = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic cpl_sent = 1'b0;
    logic [31:0] reg_rdata;
    logic reg_done, full_reset_req, warm_reset_req, upstream_retrain_req, core_hold;
    logic write_when_unlocked, power_value_write_enable, no_linkdown_warm_reset;
    logic skip_eeprom_on_warm_reset, force_strict_ordering, block_peer_traffic;
    logic eeprom_init_mode;
    logic [31:0] pol;
    int errors = 0;
    int total_checks = 0;

    // level outputs gathered into one word for comparison
    assign pol = {24'h0, core_hold, block_peer_traffic, force_strict_ordering,
        skip_eeprom_on_warm_reset, no_linkdown_warm_reset, power_value_write_enable,
        write_when_unlocked, eeprom_init_mode};

    sgcs_regs i_sgcs_regs (
        .core_clk, .rst_n, .clk_en, .warm_rst, .reset_op, .operating_mode_strap,
        .common_clock_downstream_strap(straps[0]), .common_clock_upstream_strap(straps[1]),
        .master_serial_slow_strap(straps[2]), .reference_clock_mode_strap(straps[3]),
        .reset_hold_strap(straps[4]), .upstream_lock_state, .reg_req, .reg_wr,
        .reg_eeprom, .reg_addr, .reg_wdata, .reg_rdata, .reg_done, .cpl_sent,
        .full_reset_req, .warm_reset_req, .upstream_retrain_req, .core_hold,
        .write_when_unlocked, .power_value_write_enable, .no_linkdown_warm_reset,
        .skip_eeprom_on_warm_reset, .force_strict_ordering, .block_peer_traffic,
        .eeprom_init_mode
    );

    // clock
    always #5 core_clk = ~core_clk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one register access, waits a bounded time for the done pulse
    task automatic bus(input logic wr, input logic ee, input logic [11:0] addr,
            input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge core_clk);
        #1;
        reg_req = 1'b1;
        reg_wr = wr;
        reg_eeprom = ee;
        reg_addr = addr;
        reg_wdata = wd;
        @(posedge core_clk);
        #1;
        reg_req = 1'b0;
        n = 0;
        while (reg_done !== 1'b1 && n < 4) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("reg_done", 32'h1, {31'h0, reg_done});
        rd = reg_rdata;
    endtask

    task automatic wr(input logic [11:0] addr, input logic [31:0] wd, input logic ee);
        logic [31:0] v;
        bus(1'b1, ee, addr, wd, v);
    endtask

    task automatic rd(input string what, input logic [11:0] addr, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, 1'b0, addr, 32'h0000_0000, v);
        chk(what, exp, v);
    endtask

    // straps captured once, later pin changes invisible
    task automatic t_straps();
        rd("status", SGCS_STATUS_OFFSET, 32'h0000_02A1);
        chk("levels", 32'h0000_0081, pol);
        rd("control", SGCS_CONTROL_OFFSET, 32'h0000_0004);
        straps = 5'h0A;
        repeat (3) @(posedge core_clk);
        rd("status", SGCS_STATUS_OFFSET, 32'h0000_02A1);
        rd("unmapped", 12'h408, 32'h0000_0000);
    endtask

    // each legal lock code reaches the status field
    task automatic t_lock();
        logic [2:0] codes [3] = '{SGCS_LOCK_NONE, SGCS_LOCK_PORT2, SGCS_LOCK_PORT4};
        for (int i = 0; i < 3; i++) begin
            upstream_lock_state = codes[i];
            repeat (2) @(posedge core_clk);
            rd("lock", SGCS_STATUS_OFFSET, 32'h0000_02A1 | {9'h0, codes[i], 20'h0});
        end
        upstream_lock_state = SGCS_LOCK_NONE;
    endtask

    // marker writable, other status bits not, warm reset keeps it
    task automatic t_marker();
        wr(SGCS_STATUS_OFFSET, 32'hFFFF_FFFF, 1'b0);
        rd("marker", SGCS_STATUS_OFFSET, 32'hF000_02A1);
        warm_rst = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 warm_rst = 1'b0;
        rd("marker warm", SGCS_STATUS_OFFSET, 32'hF000_02A1);
    endtask

    // clock enable low: a write neither lands nor is answered
    task automatic t_freeze();
        @(posedge core_clk);
        #1;
        clk_en = 1'b0;
        reg_req = 1'b1;
        reg_wr = 1'b1;
        reg_addr = SGCS_STATUS_OFFSET;
        reg_wdata = 32'h0000_0000;
        repeat (2) @(posedge core_clk);
        #1;
        chk("frozen done", 32'h0, {31'h0, reg_done});
        reg_req = 1'b0;
        clk_en = 1'b1;
        rd("frozen marker", SGCS_STATUS_OFFSET, 32'hF000_02A1);
    endtask

    // trigger write, no pulse before completion, then count pulses
    task automatic t_trig(input logic [31:0] wd, input int ef, input int ew);
        int nf, nw, nr;
        nf = 0;
        nw = 0;
        nr = 0;
        wr(SGCS_CONTROL_OFFSET, wd, 1'b0);
        repeat (5) begin
            @(posedge core_clk);
            #1;
            nf += (full_reset_req !== 1'b0);
            nw += (warm_reset_req !== 1'b0) + (upstream_retrain_req !== 1'b0);
        end
        chk("early request", 32'h0, nf + nw);
        cpl_sent = 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            #1;
            if (i == 0) begin
                cpl_sent = 1'b0;
            end
            nf += (full_reset_req === 1'b1);
            nw += (warm_reset_req === 1'b1);
            nr += (upstream_retrain_req === 1'b1);
        end
        chk("full pulses", ef, nf);
        chk("warm pulses", ew, nw);
        chk("retrain pulses", ew, nr);
        rd("control", SGCS_CONTROL_OFFSET, 32'h0000_0004);
    endtask

    // locked and unlocked writes of the policy and gate bits
    task automatic t_policy();
        wr(SGCS_CONTROL_OFFSET, 32'h0000_01F4, 1'b0);
        rd("control", SGCS_CONTROL_OFFSET, 32'h0000_01E4);
        chk("levels", 32'h0000_00F9, pol);
        wr(SGCS_CONTROL_OFFSET, 32'h0000_000C, 1'b0);
        chk("levels", 32'h0000_0083, pol);
        wr(SGCS_CONTROL_OFFSET, 32'h0000_001C, 1'b0);
        chk("levels", 32'h0000_0087, pol);
        wr(SGCS_CONTROL_OFFSET, 32'h0000_000C, 1'b0);
        wr(SGCS_CONTROL_OFFSET, 32'h0000_0004, 1'b0);
        wr(SGCS_CONTROL_OFFSET, 32'h0000_0014, 1'b0);
        chk("levels", 32'h0000_0081, pol);
    endtask

    // reset operation sets unlock and reloads hold, loader clears hold
    task automatic t_hold();
        reset_op = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 reset_op = 1'b0;
        rd("control", SGCS_CONTROL_OFFSET, 32'h0000_0008);
        chk("levels", 32'h0000_0003, pol);
        straps = 5'h1A;
        repeat (4) @(posedge core_clk);
        #1 reset_op = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 reset_op = 1'b0;
        wr(SGCS_CONTROL_OFFSET, 32'h0000_0008, 1'b0);
        rd("control", SGCS_CONTROL_OFFSET, 32'h0000_000C);
        wr(SGCS_CONTROL_OFFSET, 32'h0000_0008, 1'b1);
        chk("levels", 32'h0000_0003, pol);
    endtask

    // mid-run fundamental reset clears the marker and takes the straps again
    task automatic t_reset();
        @(posedge core_clk);
        #1 rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge core_clk);
        rd("status reset", SGCS_STATUS_OFFSET, 32'h0000_0341);
        rd("control reset", SGCS_CONTROL_OFFSET, 32'h0000_0004);
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge core_clk);
        t_straps();
        t_lock();
        t_marker();
        t_freeze();
        t_trig(32'h0000_0005, 1, 0);
        t_trig(32'h0000_0006, 0, 1);
        t_trig(32'h0000_0004, 0, 0);
        t_policy();
        t_hold();
        t_reset();
        test_done();
    end

    // watchdog
    initial begin
        #50000;
        errors++;
        test_done();
    end
endmodule
